// ==== xbsp_serial_port.sv ====
// Serial control port of the 8 x 10 crosspoint switch array.
`timescale 1ns/100ps
`include "xbsp_defines.svh"

module xbsp_serial_port (
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	input  wire logic                     i_scl,
	input  wire logic                     i_sda,
	output logic                          o_sda,
	output logic                          o_sda_oe,
	output logic [`XBSP_NUM_SW-1:0]       o_switch
);

	// ------------------------------------------------------------------------
	// Line events.
	// ------------------------------------------------------------------------
	xbsp_line_if line ();  // Synchronised events shared with the engine.

	xbsp_line_sync u_sync (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_scl  (i_scl),
		.i_sda  (i_sda),
		.line   (line)
	);

	// ------------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------------
	xbsp_pkg::xbsp_state_type   state;          // Engine state.
	xbsp_pkg::xbsp_state_type   next_state;     // Next engine state.
	logic [2:0]                 bitcnt;         // Bit position within a byte.
	logic [2:0]                 next_bitcnt;    // Next bit position.
	logic [7:0]                 shreg;          // Receive or transmit shifter.
	logic [7:0]                 next_shreg;     // Next shifter value.
	logic                       sda_oe;         // High while pulling data low.
	logic                       next_oe;        // Next pull-down enable.
	logic                       byte_idx;       // First or second data byte.
	logic                       next_byte_idx;  // Next byte index.
	logic                       is_read;        // Direction of current transfer.
	logic                       next_is_read;   // Next direction.
	logic [7:0]                 cmd;            // First data byte of a write.
	logic [7:0]                 next_cmd;       // Next command byte.
	logic [7:0]                 rb;             // Readback status register.
	logic [7:0]                 next_rb;        // Next readback value.
	logic [`XBSP_NUM_SW-1:0]    switch_st;      // Switch on/off states.
	logic [`XBSP_NUM_SW-1:0]    next_switch;    // Next switch states.
	logic                       apply;          // Pulse: second write byte done.
	logic [7:0]                 rx_full;        // Byte including the current bit.

	assign rx_full = {shreg[6:0], line.sda};

	// ------------------------------------------------------------------------
	// Command decode.
	// ------------------------------------------------------------------------
	logic       rb_hit;  // Command is a readback code.
	logic [3:0] rb_idx;  // Line addressed by the readback code.
	logic       x_ok;    // Command names a real line.
	logic [3:0] x_idx;   // Line addressed by the command.
	logic [2:0] y_idx;   // Column addressed by the command.

	// Readback codes are checked first; they share line fields with reserved ones.
	always_comb begin
		rb_hit = 1'h1;
		rb_idx = 4'h0;
		case (cmd)
			`XBSP_RB_X0: rb_idx = 4'h0;  // [RQ10]
			`XBSP_RB_X1: rb_idx = 4'h1;
			`XBSP_RB_X2: rb_idx = 4'h2;
			`XBSP_RB_X3: rb_idx = 4'h3;
			`XBSP_RB_X4: rb_idx = 4'h4;
			`XBSP_RB_X5: rb_idx = 4'h5;
			`XBSP_RB_X6: rb_idx = 4'h6;
			`XBSP_RB_X7: rb_idx = 4'h7;
			`XBSP_RB_X8: rb_idx = 4'h8;
			`XBSP_RB_X9: rb_idx = 4'h9;  // [RQ12]
			default:     rb_hit = 1'h0;
		endcase
	end

	// Line select field; unlisted codes are reserved and touch nothing.
	always_comb begin
		x_ok  = 1'h1;
		x_idx = 4'h0;
		y_idx = cmd[`XBSP_Y_MSB:`XBSP_Y_LSB];
		case (cmd[`XBSP_X_MSB:`XBSP_X_LSB])
			`XBSP_XSEL_X0: x_idx = 4'h0;
			`XBSP_XSEL_X1: x_idx = 4'h1;
			`XBSP_XSEL_X2: x_idx = 4'h2;
			`XBSP_XSEL_X3: x_idx = 4'h3;
			`XBSP_XSEL_X4: x_idx = 4'h4;
			`XBSP_XSEL_X5: x_idx = 4'h5;
			`XBSP_XSEL_X6: x_idx = 4'h6;
			`XBSP_XSEL_X7: x_idx = 4'h7;
			`XBSP_XSEL_X8: x_idx = 4'h8;
			`XBSP_XSEL_X9: x_idx = 4'h9;
			default:       x_ok  = 1'h0;  // [RQ13]
		endcase
	end

	// ------------------------------------------------------------------------
	// Switch array update.
	// ------------------------------------------------------------------------
	// Each switch compares its own coordinates, so only one can ever change.
	genvar gi;
	generate
		for (gi = 0; gi < `XBSP_NUM_SW; gi = gi + 1) begin : g_sw
			assign next_switch[gi] = (apply && !rb_hit && x_ok &&
				x_idx == 4'(gi / `XBSP_NUM_Y) && y_idx == 3'(gi % `XBSP_NUM_Y)) ?
				cmd[`XBSP_ON_BIT] : switch_st[gi];  // [RQ3] [RQ13]
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Protocol engine next state.
	// ------------------------------------------------------------------------
	// Data is sampled on rising clock edges and driven after falling ones.
	always_comb begin
		next_state    = state;
		next_bitcnt   = bitcnt;
		next_shreg    = shreg;
		next_oe       = sda_oe;
		next_byte_idx = byte_idx;
		next_is_read  = is_read;
		next_cmd      = cmd;
		next_rb       = rb;
		apply         = 1'h0;
		if (line.start) begin
			// A start, repeated or not, always restarts address reception.
			next_state    = xbsp_pkg::XBSP_ADDR;
			next_bitcnt   = 3'h0;
			next_oe       = 1'h0;
			next_byte_idx = 1'h0;
		end else if (line.stop) begin
			next_state = xbsp_pkg::XBSP_IDLE;
			next_oe    = 1'h0;
		end else begin
			case (state)
				xbsp_pkg::XBSP_IDLE: begin
					next_oe = 1'h0;
				end
				xbsp_pkg::XBSP_ADDR: begin
					if (line.scl_rise) begin
						next_shreg  = rx_full;
						next_bitcnt = bitcnt + 3'h1;
						if (bitcnt == `XBSP_LAST_BIT) begin
							if (rx_full[7:1] == `XBSP_DEV_ADDR) begin
								next_state   = xbsp_pkg::XBSP_ADDR_ACK;  // [RQ1]
								next_is_read = rx_full[0];  // [RQ5] [RQ7]
							end else begin
								next_state = xbsp_pkg::XBSP_IDLE;
							end
						end
					end
				end
				xbsp_pkg::XBSP_ADDR_ACK: begin
					// First fall opens the acknowledge slot, the second closes it.
					if (line.scl_fall) begin
						if (!sda_oe) begin
							next_oe = 1'h1;  // [RQ1]
						end else if (is_read) begin
							next_shreg  = `XBSP_READ_PAD;  // [RQ8]
							next_oe     = ~next_shreg[7];
							next_bitcnt = 3'h0;
							next_state  = xbsp_pkg::XBSP_RD_BYTE;
						end else begin
							next_oe     = 1'h0;
							next_bitcnt = 3'h0;
							next_state  = xbsp_pkg::XBSP_WR_BYTE;
						end
					end
				end
				xbsp_pkg::XBSP_WR_BYTE: begin
					if (line.scl_rise) begin
						next_shreg  = rx_full;
						next_bitcnt = bitcnt + 3'h1;
						if (bitcnt == `XBSP_LAST_BIT) begin
							next_state = xbsp_pkg::XBSP_WR_ACK;  // [RQ2]
							if (!byte_idx) begin
								next_cmd = rx_full;
							end else begin
								// Second byte is filler for readback, ignored here.
								apply = 1'h1;  // [RQ5]
								if (rb_hit) begin
									next_rb = switch_st[{rb_idx, 3'h0} +: 8];  // [RQ4] [RQ6]
								end
							end
						end
					end
				end
				xbsp_pkg::XBSP_WR_ACK: begin
					if (line.scl_fall) begin
						if (!sda_oe) begin
							next_oe = 1'h1;  // [RQ2]
						end else begin
							// A third byte is not acknowledged; the master should stop.
							next_oe       = 1'h0;
							next_bitcnt   = 3'h0;
							next_byte_idx = 1'h1;
							next_state    = byte_idx ? xbsp_pkg::XBSP_IDLE : xbsp_pkg::XBSP_WR_BYTE;
						end
					end
				end
				xbsp_pkg::XBSP_RD_BYTE: begin
					if (line.scl_fall) begin
						if (bitcnt == `XBSP_LAST_BIT) begin
							next_oe    = 1'h0;
							next_state = xbsp_pkg::XBSP_RD_ACK;
						end else begin
							next_shreg  = {shreg[6:0], 1'h0};
							next_oe     = ~shreg[6];
							next_bitcnt = bitcnt + 3'h1;
						end
					end
				end
				xbsp_pkg::XBSP_RD_ACK: begin
					// A not-acknowledge from the master ends the read.
					if (line.scl_rise) begin
						next_byte_idx = ~byte_idx;
						next_state    = line.sda ? xbsp_pkg::XBSP_IDLE : xbsp_pkg::XBSP_RD_NEXT;
					end
				end
				xbsp_pkg::XBSP_RD_NEXT: begin
					if (line.scl_fall) begin
						next_shreg  = byte_idx ? rb : `XBSP_READ_PAD;  // [RQ8] [RQ9]
						next_oe     = ~next_shreg[7];
						next_bitcnt = 3'h0;
						next_state  = xbsp_pkg::XBSP_RD_BYTE;
					end
				end
				default: begin
					next_state = xbsp_pkg::XBSP_IDLE;
					next_oe    = 1'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------------------
	// No reset behaviour is defined for the array, so all switches start open.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state     <= xbsp_pkg::XBSP_IDLE;
			bitcnt    <= 3'h0;
			shreg     <= 8'h00;
			sda_oe    <= 1'h0;
			byte_idx  <= 1'h0;
			is_read   <= 1'h0;
			cmd       <= 8'h00;
			rb        <= `XBSP_RB_RST;
			switch_st <= `XBSP_SWITCH_RST;
		end else begin
			state     <= next_state;
			bitcnt    <= next_bitcnt;
			shreg     <= next_shreg;
			sda_oe    <= next_oe;
			byte_idx  <= next_byte_idx;
			is_read   <= next_is_read;
			cmd       <= next_cmd;
			rb        <= next_rb;
			switch_st <= next_switch;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------------------
	// The pin is open drain: the driven level is always low.
	assign o_sda    = 1'h0;
	assign o_sda_oe = sda_oe;
	assign o_switch = switch_st;

endmodule : xbsp_serial_port

// ==== xbsp_defines.svh ====
// Constants of the crosspoint switch serial port: addresses, field positions, codes and reset values.
//
// Operation
// [RQ1] Address byte first, device acknowledges by pulling low.
// [RQ2] Write carries two data bytes, both acknowledged.
// [RQ3] Write changes only the selected switch.
// [RQ4] All eighty switches readable, one line each.
// [RQ5] Master arms readback: code byte plus filler.
// [RQ6] Readback code copies line states into register.
// [RQ7] Master reads with the direction bit set.
// [RQ8] Read returns two bytes, first all zeros.
// [RQ9] Second read byte: one means switch closed.
// [RQ10] Decode readback codes for lines zero to eight.
// [RQ11] Runs at 100 kHz, 400 kHz, 3.4 MHz.
// [RQ12] Line nine readback code is 01111110.
// [RQ13] Command byte: on bit, line, column; reserved ignored.
`ifndef XBSP_DEFINES_SVH
`define XBSP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Bus address and array shape.
// ----------------------------------------------------------------------------
`define XBSP_DEV_ADDR     7'h70
`define XBSP_NUM_X        10
`define XBSP_NUM_Y        8
`define XBSP_NUM_SW       80
`define XBSP_SWITCH_RST   80'h0
`define XBSP_READ_PAD     8'h00
`define XBSP_RB_RST       8'h00
`define XBSP_LAST_BIT     3'h7

// ----------------------------------------------------------------------------
// Command byte field positions.
// ----------------------------------------------------------------------------
`define XBSP_ON_BIT       7
`define XBSP_X_MSB        6
`define XBSP_X_LSB        3
`define XBSP_Y_MSB        2
`define XBSP_Y_LSB        0

// ----------------------------------------------------------------------------
// Line select codes in the command byte.
// ----------------------------------------------------------------------------
`define XBSP_XSEL_X0      4'h2
`define XBSP_XSEL_X1      4'h3
`define XBSP_XSEL_X2      4'h4
`define XBSP_XSEL_X3      4'h5
`define XBSP_XSEL_X4      4'h8
`define XBSP_XSEL_X5      4'h9
`define XBSP_XSEL_X6      4'hA
`define XBSP_XSEL_X7      4'hB
`define XBSP_XSEL_X8      4'hC
`define XBSP_XSEL_X9      4'hD

// ----------------------------------------------------------------------------
// Readback codes, most significant bit first.
// ----------------------------------------------------------------------------
`define XBSP_RB_X0        8'h74
`define XBSP_RB_X1        8'h7C
`define XBSP_RB_X2        8'h35
`define XBSP_RB_X3        8'h3D
`define XBSP_RB_X4        8'h75
`define XBSP_RB_X5        8'h7D
`define XBSP_RB_X6        8'h36
`define XBSP_RB_X7        8'h3E
`define XBSP_RB_X8        8'h76
`define XBSP_RB_X9        8'h7E

`endif

// ==== xbsp_pkg.sv ====
// Types shared by the crosspoint switch serial port modules.
package xbsp_pkg;

	// Protocol engine states.
	typedef enum logic [2:0] {
		XBSP_IDLE,
		XBSP_ADDR,
		XBSP_ADDR_ACK,
		XBSP_WR_BYTE,
		XBSP_WR_ACK,
		XBSP_RD_BYTE,
		XBSP_RD_ACK,
		XBSP_RD_NEXT
	} xbsp_state_type;

endpackage : xbsp_pkg

// ==== xbsp_line_if.sv ====
// Interface carrying the synchronised serial line events to the protocol engine.
`timescale 1ns/100ps

interface xbsp_line_if;
	logic scl_rise;  // One-cycle pulse on a clock rising edge.
	logic scl_fall;  // One-cycle pulse on a clock falling edge.
	logic start;     // One-cycle pulse on a start condition.
	logic stop;      // One-cycle pulse on a stop condition.
	logic sda;       // Synchronised data level.

	modport sync (output scl_rise, output scl_fall, output start, output stop, output sda);
	modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : xbsp_line_if

// ==== xbsp_line_sync.sv ====
// Two-stage synchroniser and edge detector for the serial clock and data pins.
`timescale 1ns/100ps

module xbsp_line_sync (
	input  wire logic  i_clk,
	input  wire logic  i_rstn,
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	xbsp_line_if.sync  line
);

	// ------------------------------------------------------------------------
	// Synchroniser stages.
	// ------------------------------------------------------------------------
	logic scl_meta;  // First stage, read only by the second.
	logic scl_sync;  // Second stage, safe to use.
	logic scl_dly;   // Previous value for edge detection.
	logic sda_meta;  // First stage, read only by the second.
	logic sda_sync;  // Second stage, safe to use.
	logic sda_dly;   // Previous value for edge detection.

	// The lines idle high, so reset to high to avoid a false start at release.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			scl_meta <= 1'h1;
			scl_sync <= 1'h1;
			scl_dly  <= 1'h1;
			sda_meta <= 1'h1;
			sda_sync <= 1'h1;
			sda_dly  <= 1'h1;
		end else begin
			scl_meta <= i_scl;
			scl_sync <= scl_meta;
			scl_dly  <= scl_sync;
			sda_meta <= i_sda;
			sda_sync <= sda_meta;
			sda_dly  <= sda_sync;
		end
	end

	// ------------------------------------------------------------------------
	// Edge and condition decode.
	// ------------------------------------------------------------------------
	// Sampling at 200 MHz leaves over 50 samples per 3.4 MHz clock period. [RQ11]
	// Both lines share the same latency, so data set up after a falling clock
	// edge is never seen on the wrong side of the next rising edge.
	assign line.scl_rise = scl_sync & ~scl_dly;
	assign line.scl_fall = ~scl_sync & scl_dly;
	assign line.start    = scl_sync & scl_dly & sda_dly & ~sda_sync;
	assign line.stop     = scl_sync & scl_dly & ~sda_dly & sda_sync;
	assign line.sda      = sda_sync;

endmodule : xbsp_line_sync

// ==== xbsp_serial_port_properties.sv ====
// Concurrent checks on the pins of the crosspoint switch serial port.
`timescale 1ns/100ps
`include "xbsp_defines.svh"

module xbsp_serial_port_properties (
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	input  wire logic                     i_scl,
	input  wire logic                     i_sda,
	input  wire logic                     o_sda,
	input  wire logic                     o_sda_oe,
	input  wire logic [`XBSP_NUM_SW-1:0]  o_switch
);
	// ------------------------------------------------------------------
	// One clock domain, so one default clock and one default disable.
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	AST_PULL_LOW_ONLY: assert property (o_sda_oe |-> o_sda == 1'h0)
		else $error("Data pin driven high while enabled.");
	AST_QUIET_AFTER_RESET: assert property ($rose(i_rstn) |-> !o_sda_oe && o_switch == '0)
		else $error("Outputs not idle after reset release.");
	// Data may only move a few cycles after a clock fall, never while the clock is high.
	AST_DRIVE_AFTER_FALL: assert property ($changed(o_sda_oe) |-> !$past(i_scl) && $past(i_scl, 6))
		else $error("Data drive changed outside the clock low phase.");
	AST_DRIVE_HOLDS: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
		else $error("Acknowledge or data bit held too briefly.");
	AST_DRIVE_ENDS: assert property ($rose(o_sda_oe) |-> ##[1:500] !o_sda_oe)
		else $error("Data pin held low for too long.");
	AST_UPDATE_CLOCK_HIGH: assert property ($changed(o_switch) |-> i_scl)
		else $error("Switch array changed while the clock was low.");
	AST_UPDATE_AFTER_RISE: assert property ($changed(o_switch) |-> !$past(i_scl, 8))
		else $error("Switch array changed without a recent clock rise.");
	AST_ONE_SWITCH: assert property ($changed(o_switch) |-> $onehot(o_switch ^ $past(o_switch)))
		else $error("More than one switch changed at once.");

	// Main scenarios: acknowledge, a switch closing and a switch opening.
	cover property ($rose(o_sda_oe));
	cover property ($changed(o_switch) && $countones(o_switch) > $countones($past(o_switch)));
	cover property ($changed(o_switch) && $countones(o_switch) < $countones($past(o_switch)));
endmodule : xbsp_serial_port_properties

bind xbsp_serial_port xbsp_serial_port_properties i_xbsp_serial_port_properties (.i_clk(i_clk),
	.i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_switch(o_switch));

// ==== xbsp_i2c_master.sv ====
// Bus master model that drives the serial clock and data lines of the switch port.
`timescale 1ns/100ps

module xbsp_i2c_master (
	input  wire logic  i_clk,
	input  wire logic  i_dev_sda,
	input  wire logic  i_dev_sda_oe,
	output logic       o_scl,
	output logic       o_sda
);
	logic drv_sda;     // Master side of the data line, 1 means released.
	int   stretch = 1; // Phase multiplier; 2 gives a slow master.

	// Wired-AND with a pull-up, so a released line reads high.
	assign o_sda = drv_sda & (i_dev_sda_oe ? i_dev_sda : 1'h1);

	// The clock idles high and stands still between frames.
	initial begin
		o_scl   = 1'h1;
		drv_sda = 1'h1;
	end

	// One bit time: quarters of 6, 6, 6 and 7 cycles give 125 ns at full speed.
	// Start is (1,0,0), stop is (0,1,1), a data bit is (b,b,0).
	task automatic phase(input logic d0, input logic d1, input logic scl_end, output logic r);
		repeat (6 * stretch) @(negedge i_clk);
		drv_sda = d0;
		repeat (6 * stretch) @(negedge i_clk);
		o_scl = 1'h1;
		repeat (6 * stretch) @(negedge i_clk);
		r = o_sda;
		drv_sda = d1;
		repeat (7 * stretch) @(negedge i_clk);
		o_scl = scl_end;
	endtask : phase

	// Byte transfer most significant bit first, then the acknowledge slot.
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			phase(tx[i], tx[i], 1'h0, rx[i]);
		phase(ack_in, ack_in, 1'h0, ack);
	endtask : xfer
endmodule : xbsp_i2c_master

// ==== test_xbsp_serial_port.sv ====
// Self-checking testbench of the crosspoint switch serial port.
`timescale 1ns/100ps
`include "xbsp_defines.svh"

module test_xbsp_serial_port;
	localparam logic [3:0] xsel_tab [10] = '{`XBSP_XSEL_X0, `XBSP_XSEL_X1, `XBSP_XSEL_X2, `XBSP_XSEL_X3,
		`XBSP_XSEL_X4, `XBSP_XSEL_X5, `XBSP_XSEL_X6, `XBSP_XSEL_X7, `XBSP_XSEL_X8, `XBSP_XSEL_X9};
	localparam logic [7:0] rb_tab [10] = '{`XBSP_RB_X0, `XBSP_RB_X1, `XBSP_RB_X2, `XBSP_RB_X3,
		`XBSP_RB_X4, `XBSP_RB_X5, `XBSP_RB_X6, `XBSP_RB_X7, `XBSP_RB_X8, `XBSP_RB_X9};
	localparam logic [3:0] rsv_tab [6] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'hE, 4'hF};
	localparam logic [7:0] addr_w = {`XBSP_DEV_ADDR, 1'h0};

	logic                    i_clk = 1'h0;
	logic                    i_rstn = 1'h0;
	logic                    scl;
	logic                    sda;
	logic                    dev_sda;
	logic                    dev_sda_oe;
	logic [`XBSP_NUM_SW-1:0] sw;
	logic [`XBSP_NUM_SW-1:0] exp_sw = '0; // Expected switch array.
	logic [31:0]             seed = 32'h2F0579B5;
	logic [31:0]             r;
	logic [7:0]              c;
	logic [7:0]              rx;
	logic                    ack;
	int                      n_errors = 0;
	int                      num_checks = 0;

	xbsp_serial_port i_xbsp_serial_port (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda),
		.o_sda(dev_sda), .o_sda_oe(dev_sda_oe), .o_switch(sw));
	xbsp_i2c_master i_xbsp_i2c_master (.i_clk(i_clk), .i_dev_sda(dev_sda), .i_dev_sda_oe(dev_sda_oe),
		.o_scl(scl), .o_sda(sda));

	always #2.5 i_clk = ~i_clk;

	// ------------------------------------------------------------------
	// Expectation and comparison helpers.
	// ------------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Only a command whose line field is a known select touches one switch; all else is ignored.
	function automatic logic [79:0] apply_cmd(input logic [79:0] s, input logic [7:0] cmd);
		for (int x = 0; x < 10; x++)
			if (cmd[6:3] === xsel_tab[x]) s[x*8 + cmd[2:0]] = cmd[7];
		return s;
	endfunction : apply_cmd

	task chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk_bit

	task chk_vec(input logic [79:0] got, input logic [79:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk_vec

	task stop_test();
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------------
	// Bus sequences built on the master model.
	// ------------------------------------------------------------------
	task st();
		i_xbsp_i2c_master.phase(1'h1, 1'h0, 1'h0, ack);
	endtask : st

	task sp();
		i_xbsp_i2c_master.phase(1'h0, 1'h1, 1'h1, ack);
	endtask : sp

	task put(input logic [7:0] b, input logic e);
		i_xbsp_i2c_master.xfer(b, 1'h1, rx, ack);
		chk_bit(ack, e);
	endtask : put

	task get(input logic a);
		i_xbsp_i2c_master.xfer(8'hFF, a, rx, ack);
	endtask : get

	task wr(input logic [7:0] cmd, input logic [7:0] f);
		st();
		put(addr_w, 1'h0);
		put(cmd, 1'h0);
		put(f, 1'h0);
		sp();
		exp_sw = apply_cmd(exp_sw, cmd);
		chk_vec(sw, exp_sw);
	endtask : wr

	// Readback of one line; rs picks a repeated start instead of stop then start.
	task automatic rdback(input int x, input logic rs);
		st();
		put(addr_w, 1'h0);
		put(rb_tab[x], 1'h0);
		put(8'(rnd()), 1'h0);
		if (!rs) sp();
		st();
		put({`XBSP_DEV_ADDR, 1'h1}, 1'h0);
		get(1'h0);
		chk_vec(80'(rx), 80'h0);
		get(1'h1);
		chk_vec(80'(rx), 80'(exp_sw[x*8 +: 8]));
		sp();
		chk_vec(sw, exp_sw);
	endtask : rdback

	// The tests need about 292 us even with every random write slowed down.
	// A hung handshake therefore ends the run as a failure at 400 us, well inside the cycle budget.
	initial begin
		#400us;
		n_errors++;
		stop_test();
	end

	initial begin
		repeat (16) @(negedge i_clk);
		chk_vec(sw, 80'h0);
		chk_bit(dev_sda_oe, 1'h0);
		i_rstn = 1'h1;
		repeat (8) @(negedge i_clk);
		// One switch closed on every line so that each readback has a known one.
		for (int x = 0; x < 10; x++)
			wr({1'h1, xsel_tab[x], 3'(x)}, 8'hA5);
		// Random opens and closes, with a slow master now and then.
		repeat (20) begin
			r = rnd();
			i_xbsp_i2c_master.stretch = 1 + int'(r[31]);
			wr({r[0], xsel_tab[r[11:8] % 10], r[6:4]}, r[23:16]);
		end
		i_xbsp_i2c_master.stretch = 1;
		// Reserved line fields must leave the array alone.
		for (int k = 0; k < 6; k++)
			wr({1'h1, rsv_tab[k], 3'(rnd())}, 8'h3C);
		for (int x = 0; x < 10; x++)
			rdback(x, x[0]);
		// Another address: no acknowledge and no effect.
		st();
		put({`XBSP_DEV_ADDR ^ 7'h01, 1'h0}, 1'h1);
		put({1'h1, xsel_tab[0], 3'h7}, 1'h1);
		sp();
		chk_vec(sw, exp_sw);
		// Command byte alone: nothing applied.
		st();
		put(addr_w, 1'h0);
		put({1'h1, xsel_tab[9], 3'h6}, 1'h0);
		sp();
		chk_vec(sw, exp_sw);
		// Third data byte is refused; the first two still apply.
		c = {~exp_sw[0], xsel_tab[0], 3'h0};
		st();
		put(addr_w, 1'h0);
		put(c, 1'h0);
		put(8'h5A, 1'h0);
		put(8'h33, 1'h1);
		sp();
		exp_sw = apply_cmd(exp_sw, c);
		chk_vec(sw, exp_sw);
		rdback(0, 1'h1);
		stop_test();
	end
endmodule : test_xbsp_serial_port
